// ---- cmd_block_decoder.sv ----
// fetches a 40-byte command block from memory, decodes it and drives the scsi engine
// Function
// - block is 40 bytes: opcode, control, cdb length, sense length, cdb at 18-29
// - data pointer is the full 32-bit word in bytes 8 to 11
// - multi-byte fields are little endian, least significant byte first
// - data length is the four-byte count in bytes 4 to 7
// - target from byte 16, lun and tag from byte 17
// - sense data goes to the 32-bit sense pointer in bytes 36-39
// - opcode 00 issues initiator command with byte count and transfer address
// - opcode 02 issues command with segment list size and address
// - opcode 03 direct transfer with length checking and residual returned
// - opcode 04 segment list transfer with length checking and residual
// - opcode 81 sends bus device reset to the selected target
// - bus device reset aborts target tasks and ignores remaining block bytes
// - control bits 7-5 ignored, bits 4-3 select transfer direction
// - direction 00 lets the scsi command decide
// - direction 01 moves data from scsi device toward adapter only
// - direction 10 is data out with checking, 11 moves no data
// - busy target status requeues and restarts the same command, except after a bus device reset
`timescale 1ns/1ps
`include "cmd_block_map.svh"
module cmd_block_decoder
   import cmd_block_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // avalon-mm register slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   // memory read master for the command block
   output logic                   mem_read,
   output logic      [31:0]       mem_address,
   input  wire logic              mem_waitrequest,
   input  wire logic [31:0]       mem_readdata,
   input  wire logic              mem_readdatavalid,
   // command to the scsi engine
   output logic                   scsi_cmd_valid,
   output kind_e                  scsi_kind,
   output logic      [1:0]        scsi_dir,
   output logic                   scsi_len_check,
   output logic      [7:0]        scsi_target,
   output logic      [7:0]        scsi_lun_tag,
   output logic      [3:0]        scsi_cdb_len,
   output logic      [95:0]       scsi_cdb,
   output logic      [31:0]       scsi_xfer_len,
   output logic      [31:0]       scsi_xfer_ptr,
   output logic      [31:0]       scsi_sense_ptr,
   output logic      [7:0]        scsi_sense_len,
   // completion from the scsi engine
   input  wire logic              scsi_done,
   input  wire logic [7:0]        scsi_target_status,
   input  wire logic [7:0]        scsi_adapter_result,
   input  wire logic [31:0]       scsi_residual
);
   dec_s state_ff;
   dec_s nxt_state;
   logic done_sync;
   logic [7:0] opcode;
   logic [7:0] cdb_len_raw;
   logic [3:0] cdb_len_lim;
   logic [95:0] cdb_masked;
   logic [7:0] reg_sel;

   if (ADDR_W < 6 || ADDR_W > 8)
   begin : g_chk
      $error("cmd_block_decoder address width must be 6 to 8 bits");
   end

   // completion level comes from another domain
   level_sync #(.W(1)) u_done_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (scsi_done),
      .q     (done_sync)
   );

   // field decode from the fetched words
   always_comb
   begin
      opcode      = `CB_OPCODE(state_ff.words);
      cdb_len_raw = `CB_CDB_LEN(state_ff.words);
      cdb_len_lim = (cdb_len_raw > `CDB_MAX) ? 4'(`CDB_MAX) : cdb_len_raw[3:0];
      cdb_masked  = `CB_CDB(state_ff.words);
      for (int i = 0; i < `CDB_BYTES; i++)
      begin
         if (i >= int'(cdb_len_lim))
            cdb_masked[i*8 +: 8] = 8'h00;
      end
      reg_sel = 8'(avs_address);
   end

   // sequencer, register slave and memory master
   always_comb
   begin
      nxt_state = state_ff;
      // register slave: one wait cycle, then the access takes effect
      if ((avs_read || avs_write) && state_ff.waitreq)
      begin
         nxt_state.waitreq = 1'b0;
         unique case (reg_sel & 8'hFC)
            `REG_BLOCK_ADDR: nxt_state.rdata = state_ff.block_addr;
            `REG_STATUS:     nxt_state.rdata = {opcode, state_ff.target_status,
                                                state_ff.adapter_result, 6'h00,
                                                state_ff.done, state_ff.busy};
            `REG_RESIDUAL:   nxt_state.rdata = state_ff.residual;
            `REG_FIELDS:     nxt_state.rdata = {`CB_LUN_TAG(state_ff.words),
                                                `CB_TARGET(state_ff.words),
                                                4'h0, state_ff.cdb_len, 2'h0,
                                                state_ff.len_check, state_ff.dir,
                                                state_ff.kind};
            `REG_XFER_LEN:   nxt_state.rdata = state_ff.xfer_len;
            `REG_XFER_PTR:   nxt_state.rdata = state_ff.xfer_ptr;
            `REG_SENSE_PTR:  nxt_state.rdata = `CB_SENSE_PTR(state_ff.words);
            `REG_RETRIES:    nxt_state.rdata = {16'h0000, state_ff.retries};
            default:         nxt_state.rdata = 32'h0000_0000;
         endcase
      end
      else if (!state_ff.waitreq)
      begin
         nxt_state.waitreq = 1'b1;
      end
      // writes land at the edge that sees waitrequest low
      if (avs_write && !state_ff.waitreq && (reg_sel & 8'hFC) == `REG_BLOCK_ADDR)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (avs_byteenable[b])
               nxt_state.block_addr[b*8 +: 8] = avs_writedata[b*8 +: 8];
         end
      end
      // memory read accepted
      if (state_ff.mem_read && !mem_waitrequest)
         nxt_state.mem_read = 1'b0;
      unique case (state_ff.st)
         S_IDLE:
         begin
            if (avs_write && !state_ff.waitreq && (reg_sel & 8'hFC) == `REG_CTRL
                && avs_byteenable[0] && avs_writedata[`CTRL_START])
            begin
               nxt_state.busy    = 1'b1;
               nxt_state.done    = 1'b0;
               nxt_state.idx     = 4'h0;
               nxt_state.retries = 16'h0000;
               nxt_state.words   = '0; // no stale words behind a bus reset
               nxt_state.st      = S_FETCH;
            end
         end
         S_FETCH:
         begin
            nxt_state.mem_read = 1'b1;
            nxt_state.mem_addr = state_ff.block_addr + {26'h0, state_ff.idx, 2'b00};
            nxt_state.st       = S_WAIT;
         end
         S_WAIT:
         begin
            // readdata[7:0] is the lowest byte address, so words are little endian
            if (mem_readdatavalid)
            begin
               nxt_state.words[state_ff.idx] = mem_readdata;
               nxt_state.st = S_FETCH;
               if (state_ff.idx == 4'h0 && `CB_OPCODE(nxt_state.words) == `OP_BDR)
                  nxt_state.idx = `WORD_TARGET;
               else
                  nxt_state.idx = state_ff.idx + 4'h1;
               if (state_ff.idx == `BLOCK_WORDS - 4'h1 ||
                   (state_ff.idx == `WORD_TARGET && opcode == `OP_BDR))
                  nxt_state.st = S_DECODE;
            end
         end
         S_DECODE:
         begin
            nxt_state.dir       = `CB_DIR(state_ff.words);
            nxt_state.len_check = (`CB_DIR(state_ff.words) == `DIR_IN) ||
                                  (`CB_DIR(state_ff.words) == `DIR_OUT);
            nxt_state.cdb_len   = cdb_len_lim;
            nxt_state.cdb       = cdb_masked;
            nxt_state.xfer_ptr  = `CB_DATA_PTR(state_ff.words);
            if (`CB_DIR(state_ff.words) == `DIR_NONE)
               nxt_state.xfer_len = 32'h0000_0000;
            else
               nxt_state.xfer_len = `CB_DATA_LEN(state_ff.words);
            nxt_state.cmd_valid = 1'b1;
            nxt_state.st        = S_ISSUE;
            unique case (opcode)
               `OP_INIT:     nxt_state.kind = K_INIT;
               `OP_SG:       nxt_state.kind = K_SG;
               `OP_RESID:    nxt_state.kind = K_RESID;
               `OP_SG_RESID: nxt_state.kind = K_SG_RESID;
               `OP_BDR:
               begin
                  nxt_state.kind     = K_BDR;
                  nxt_state.cdb_len  = 4'h0;
                  nxt_state.cdb      = '0;
                  nxt_state.xfer_len = 32'h0000_0000;
                  nxt_state.xfer_ptr = 32'h0000_0000;
               end
               default:
               begin
                  nxt_state.cmd_valid      = 1'b0;
                  nxt_state.adapter_result = `RES_BAD_OP;
                  nxt_state.target_status  = 8'h00;
                  nxt_state.residual       = 32'h0000_0000;
                  nxt_state.st             = S_DONE;
               end
            endcase
            // direct and segment list transfers with length checking always check
            if (opcode == `OP_RESID || opcode == `OP_SG_RESID)
               nxt_state.len_check = 1'b1;
         end
         S_ISSUE:
         begin
            if (done_sync)
            begin
               nxt_state.cmd_valid      = 1'b0;
               nxt_state.target_status  = scsi_target_status;
               nxt_state.adapter_result = scsi_adapter_result;
               nxt_state.residual       = (state_ff.kind == K_RESID ||
                                           state_ff.kind == K_SG_RESID) ?
                                          scsi_residual : 32'h0000_0000;
               nxt_state.reissue        = (scsi_target_status == `TSTAT_BUSY) &&
                                          (state_ff.kind != K_BDR);
               if (scsi_target_status == `TSTAT_BUSY && state_ff.kind != K_BDR)
                  nxt_state.retries = state_ff.retries + 16'h0001;
               nxt_state.st = S_RELEASE;
            end
         end
         S_RELEASE:
         begin
            // the engine drops its completion before the next command
            if (!done_sync)
            begin
               nxt_state.reissue   = 1'b0;
               nxt_state.cmd_valid = state_ff.reissue;
               nxt_state.st        = state_ff.reissue ? S_ISSUE : S_DONE;
            end
         end
         S_DONE:
         begin
            nxt_state.busy = 1'b0;
            nxt_state.done = 1'b1;
            nxt_state.st   = S_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff            <= '0;
         state_ff.st         <= S_IDLE;
         state_ff.kind       <= K_INIT;
         state_ff.waitreq    <= 1'b1;
         state_ff.block_addr <= `BLOCK_ADDR_RST;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // outputs straight from the state register
   assign avs_readdata    = state_ff.rdata;
   assign avs_waitrequest = state_ff.waitreq;
   assign mem_read        = state_ff.mem_read;
   assign mem_address     = state_ff.mem_addr;
   assign scsi_cmd_valid  = state_ff.cmd_valid;
   assign scsi_kind       = state_ff.kind;
   assign scsi_dir        = state_ff.dir;
   assign scsi_len_check  = state_ff.len_check;
   assign scsi_target     = `CB_TARGET(state_ff.words);
   assign scsi_lun_tag    = `CB_LUN_TAG(state_ff.words);
   assign scsi_cdb_len    = state_ff.cdb_len;
   assign scsi_cdb        = state_ff.cdb;
   assign scsi_xfer_len   = state_ff.xfer_len;
   assign scsi_xfer_ptr   = state_ff.xfer_ptr;
   assign scsi_sense_ptr  = `CB_SENSE_PTR(state_ff.words);
   assign scsi_sense_len  = `CB_SENSE_LEN(state_ff.words);

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_full_fetch;
      (state_ff.st == S_DECODE && opcode != `OP_BDR) |-> state_ff.idx == `BLOCK_WORDS;
   endproperty
   a_full_fetch: assert property (p_full_fetch) else $error("block not fully fetched");
   property p_ptr;
      $rose(scsi_cmd_valid) && scsi_kind != K_BDR |-> scsi_xfer_ptr == state_ff.words[2];
   endproperty
   a_ptr: assert property (p_ptr) else $error("transfer pointer not from bytes 8-11");
   property p_len;
      $rose(scsi_cmd_valid) && scsi_kind != K_BDR && scsi_dir != `DIR_NONE
         |-> scsi_xfer_len == state_ff.words[1];
   endproperty
   a_len: assert property (p_len) else $error("transfer length not from bytes 4-7");
   property p_dir;
      scsi_cmd_valid && scsi_kind != K_BDR |-> scsi_dir == state_ff.words[0][12:11];
   endproperty
   a_dir: assert property (p_dir) else $error("direction not from control bits 4-3");
   property p_nodata;
      scsi_cmd_valid && scsi_dir == `DIR_NONE |-> scsi_xfer_len == 32'h0000_0000;
   endproperty
   a_nodata: assert property (p_nodata) else $error("no-data command has a length");
   property p_badop;
      state_ff.st == S_DECODE && !(opcode inside {`OP_INIT, `OP_SG, `OP_RESID,
         `OP_SG_RESID, `OP_BDR}) |=> !scsi_cmd_valid && state_ff.st == S_DONE
         ##1 state_ff.done && state_ff.adapter_result == `RES_BAD_OP;
   endproperty
   a_badop: assert property (p_badop) else $error("invalid opcode not rejected");
   property p_cdb_len;
      scsi_cmd_valid |-> scsi_cdb_len <= 4'(`CDB_MAX) && scsi_cdb_len <= cdb_len_raw;
   endproperty
   a_cdb_len: assert property (p_cdb_len) else $error("cdb length over limit");
   property p_busy_retry;
      state_ff.st == S_ISSUE && done_sync && scsi_target_status == `TSTAT_BUSY
         && scsi_kind != K_BDR |=> state_ff.retries == $past(state_ff.retries) + 16'h0001
         && state_ff.reissue;
   endproperty
   a_busy_retry: assert property (p_busy_retry) else $error("busy status not requeued");
   property p_bdr_skip;
      $rose(scsi_cmd_valid) && scsi_kind == K_BDR |-> scsi_cdb_len == 4'h0
         && scsi_xfer_len == 32'h0000_0000 && $past(state_ff.idx) == `WORD_TARGET + 4'h1;
   endproperty
   a_bdr_skip: assert property (p_bdr_skip) else $error("bus reset used extra bytes");
endmodule

// ---- cmd_block_map.svh ----
// register offsets, command block field layout and codes for the block decoder
`ifndef CMD_BLOCK_MAP_SVH
`define CMD_BLOCK_MAP_SVH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_BLOCK_ADDR  8'h04
`define REG_STATUS      8'h08
`define REG_RESIDUAL    8'h0C
`define REG_FIELDS      8'h10
`define REG_XFER_LEN    8'h14
`define REG_XFER_PTR    8'h18
`define REG_SENSE_PTR   8'h1C
`define REG_RETRIES     8'h20

// control bits and reset values
`define CTRL_START      0
`define BLOCK_ADDR_RST  32'h0000_0000

// command block: 40 bytes as ten little-endian words
`define BLOCK_WORDS     4'hA
`define WORD_TARGET     4'h4
`define CB_OPCODE(w)    w[0][7:0]
`define CB_DIR(w)       w[0][12:11]
`define CB_CDB_LEN(w)   w[0][23:16]
`define CB_SENSE_LEN(w) w[0][31:24]
`define CB_DATA_LEN(w)  w[1]
`define CB_DATA_PTR(w)  w[2]
`define CB_TARGET(w)    w[4][7:0]
`define CB_LUN_TAG(w)   w[4][15:8]
`define CB_CDB(w)       {w[7][15:0], w[6], w[5], w[4][31:16]}
`define CB_SENSE_PTR(w) w[9]

// operation codes
`define OP_INIT         8'h00
`define OP_SG           8'h02
`define OP_RESID        8'h03
`define OP_SG_RESID     8'h04
`define OP_BDR          8'h81

// direction codes
`define DIR_BY_CMD      2'h0
`define DIR_IN          2'h1
`define DIR_OUT         2'h2
`define DIR_NONE        2'h3

// status and result codes
`define TSTAT_BUSY      8'h08
`define RES_OK          8'h00
`define RES_BAD_OP      8'h16
`define CDB_MAX         8'h0C
`define CDB_BYTES       12

`endif

// ---- cmd_block_pkg.sv ----
// types shared by the command block decoder
package cmd_block_pkg;

   typedef enum logic [2:0] {S_IDLE, S_FETCH, S_WAIT, S_DECODE, S_ISSUE, S_RELEASE, S_DONE} seq_e;

   typedef enum logic [2:0] {K_INIT, K_SG, K_RESID, K_SG_RESID, K_BDR} kind_e;

   typedef struct packed {
      seq_e             st;
      logic [9:0][31:0] words;
      logic [3:0]       idx;
      logic             mem_read;
      logic [31:0]      mem_addr;
      logic [31:0]      block_addr;
      logic             busy;
      logic             done;
      logic [7:0]       adapter_result;
      logic [7:0]       target_status;
      logic [31:0]      residual;
      logic [15:0]      retries;
      logic             reissue;
      logic             cmd_valid;
      kind_e            kind;
      logic [1:0]       dir;
      logic             len_check;
      logic [3:0]       cdb_len;
      logic [95:0]      cdb;
      logic [31:0]      xfer_len;
      logic [31:0]      xfer_ptr;
      logic             waitreq;
      logic [31:0]      rdata;
   } dec_s;

endpackage

// ---- host_model.sv ----
// memory holding command blocks plus a scsi engine responder
`timescale 1ns/1ps
module host_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // memory read slave
   input  wire logic        mem_read,
   input  wire logic [31:0] mem_address,
   output logic             mem_waitrequest,
   output logic [31:0]      mem_readdata,
   output logic             mem_readdatavalid,
   // scsi engine completion
   input  wire logic        cmd_valid,
   input  wire logic [31:0] resid,
   output logic             done,
   output logic [7:0]       target_status,
   output logic [7:0]       adapter_result,
   output logic [31:0]      residual
);
   logic [7:0] mem [0:255];
   logic [7:0] a;
   logic [3:0] busy_left;
   logic [2:0] delay;
   int         reads;

   // one wait cycle per read; data line toggles when not valid
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         mem_waitrequest   <= 1'b1;
         mem_readdatavalid <= 1'b0;
         mem_readdata      <= 32'h0;
      end
      else
      begin
         mem_waitrequest   <= !(mem_read && mem_waitrequest);
         mem_readdatavalid <= mem_read && !mem_waitrequest;
         a = mem_address[7:0];
         if (mem_read && !mem_waitrequest)
         begin
            reads++;
            mem_readdata <= {mem[a+3], mem[a+2], mem[a+1], mem[a]};
         end
         else
            mem_readdata <= ~mem_readdata;
      end

   // answers a command a few cycles late, busy while busy_left is nonzero
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         done  <= 1'b0;
         delay <= 3'h0;
      end
      else if (cmd_valid && !done)
      begin
         delay <= delay + 3'h1;
         if (delay == 3'h3)
         begin
            done           <= 1'b1;
            target_status  <= (busy_left != 0) ? 8'h08 : 8'h00;
            adapter_result <= 8'h00;
            residual       <= resid;
            if (busy_left != 0)
               busy_left <= busy_left - 4'h1;
         end
      end
      else if (!cmd_valid && done)
      begin
         done           <= 1'b0;
         delay          <= 3'h0;
         target_status  <= ~target_status;
         adapter_result <= ~adapter_result;
         residual       <= ~residual;
      end
endmodule

// ---- level_sync.sv ----
// two-flop synchroniser for levels arriving from the scsi side
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;

   sync_s state_ff;
   sync_s nxt_state;

   if (W < 1)
   begin : g_chk
      $error("level_sync width must be at least one");
   end

   // first stage feeds only the second
   always_comb
   begin
      nxt_state.s1 = d;
      nxt_state.s2 = state_ff.s1;
   end

   // register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign q = state_ff.s2;
endmodule

// ---- tb_top.sv ----
// self-checking bench for the command block decoder
`timescale 1ns/1ps
`include "cmd_block_map.svh"
module tb_top;
   import cmd_block_pkg::*;
   logic        clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, prev_valid = 0;
   logic [7:0]  avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, mem_address, mem_readdata, q;
   logic        avs_waitrequest, mem_read, mem_waitrequest, mem_readdatavalid;
   logic        cmd_valid, len_check, done, c_chk;
   kind_e       kind, c_kind;
   logic [1:0]  dir, c_dir;
   logic [7:0]  target, lun_tag, tstat, ares, sense_len, c_tgt, c_lun, c_slen;
   logic [3:0]  cdb_len, c_clen;
   logic [95:0] cdb, c_cdb;
   logic [31:0] xfer_len, xfer_ptr, sense_ptr, residual, c_len, c_ptr, c_sense;
   logic [7:0]  blk [0:39];
   int          bad_count = 0, checked = 0, cycles = 0, issues = 0;

   always #5 clk = ~clk;

   cmd_block_decoder dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mem_read(mem_read), .mem_address(mem_address), .mem_waitrequest(mem_waitrequest),
      .mem_readdata(mem_readdata), .mem_readdatavalid(mem_readdatavalid),
      .scsi_cmd_valid(cmd_valid), .scsi_kind(kind), .scsi_dir(dir), .scsi_len_check(len_check),
      .scsi_target(target), .scsi_lun_tag(lun_tag), .scsi_cdb_len(cdb_len), .scsi_cdb(cdb),
      .scsi_xfer_len(xfer_len), .scsi_xfer_ptr(xfer_ptr), .scsi_sense_ptr(sense_ptr),
      .scsi_sense_len(sense_len), .scsi_done(done), .scsi_target_status(tstat),
      .scsi_adapter_result(ares), .scsi_residual(residual));

   host_model host (.clk(clk), .rst_n(rst_n), .mem_read(mem_read), .mem_address(mem_address),
      .mem_waitrequest(mem_waitrequest), .mem_readdata(mem_readdata),
      .mem_readdatavalid(mem_readdatavalid), .cmd_valid(cmd_valid), .resid(32'h0000_0123),
      .done(done), .target_status(tstat), .adapter_result(ares), .residual(residual));

   // capture the offered command at each rise of valid; timeout guard
   always @(posedge clk)
   begin
      if (cmd_valid === 1'b1 && !prev_valid)
      begin
         issues++;
         c_kind = kind;
         {c_dir, c_chk, c_tgt, c_lun, c_clen, c_cdb} =
            {dir, len_check, target, lun_tag, cdb_len, cdb};
         {c_len, c_ptr, c_sense, c_slen} = {xfer_len, xfer_ptr, sense_ptr, sense_len};
      end
      prev_valid = (cmd_valid === 1'b1);
      cycles++;
      if (cycles == 30000)
      begin
         bad_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [95:0] exp, input logic [95:0] got);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= ad;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // reset values, unmapped and read-only places
   task automatic t_regs();
      bus(0, `REG_STATUS, 0);
      cmp("status", 32'h0, q);
      bus(0, `REG_BLOCK_ADDR, 0);
      cmp("block_addr", `BLOCK_ADDR_RST, q);
      bus(1, 8'h3C, 32'hFFFF_FFFF);
      bus(0, 8'h3C, 0);
      cmp("unmapped", 32'h0, q);
      bus(1, `REG_STATUS, 32'hFFFF_FFFF);
      bus(0, `REG_STATUS, 0);
      cmp("status_ro", 32'h0, q);
   endtask

   // build a block, start it, wait for completion, check every field, the captured dir and len_check only when not a bus reset
   task automatic t_block(input logic [7:0] base, op, ctl, cl, input logic [3:0] nbusy);
      logic [95:0] ecdb;
      logic        bdr;
      logic        chk;
      logic [3:0]  el;
      logic [1:0]  d;
      kind_e       ek;
      int          n;
      foreach (blk[i])
         blk[i] = ((i >= 12 && i < 16) || (i >= 30 && i < 36)) ? 8'h00 : 8'(i * 29 + 3);
      {blk[0], blk[1], blk[2]} = {op, ctl, cl};
      foreach (blk[i])
         host.mem[base + i] = blk[i];
      host.busy_left = nbusy;
      host.reads = 0;
      issues = 0;
      bus(1, `REG_BLOCK_ADDR, {24'h0, base});
      bus(1, `REG_CTRL, 32'h1);
      n = 0;
      q = 0;
      while (q[1:0] !== 2'b10 && n < 300)
      begin
         bus(0, `REG_STATUS, 0);
         n++;
      end
      bdr = (op == `OP_BDR);
      d = ctl[4:3];
      chk = d == 1 || d == 2 || op == 3 || op == 4;
      el = bdr ? 4'h0 : (cl > `CDB_MAX ? 4'hC : cl[3:0]);
      ek = op == `OP_INIT ? K_INIT : op == `OP_SG ? K_SG : op == `OP_RESID ? K_RESID :
           op == `OP_SG_RESID ? K_SG_RESID : K_BDR;
      ecdb = '0;
      for (int i = 0; i < 12; i++)
         if (i < el)
            ecdb[i*8 +: 8] = blk[18 + i];
      cmp("status", {op, 24'h000002}, q);
      cmp("issues", nbusy + 1, issues);
      cmp("fetches", bdr ? 2 : 10, host.reads);
      cmp("kind", ek, c_kind);
      cmp("target", blk[16], c_tgt);
      cmp("lun_tag", blk[17], c_lun);
      cmp("cdb_len", el, c_clen);
      cmp("cdb", ecdb, c_cdb);
      cmp("xfer_ptr", bdr ? 0 : {blk[11], blk[10], blk[9], blk[8]}, c_ptr);
      cmp("xfer_len", (bdr || d == 3) ? 0 : {blk[7], blk[6], blk[5], blk[4]}, c_len);
      cmp("sense_ptr", bdr ? 0 : {blk[39], blk[38], blk[37], blk[36]}, c_sense);
      cmp("sense_len", blk[3], c_slen);
      if (!bdr)
      begin
         cmp("dir", d, c_dir);
         cmp("len_check", chk, c_chk);
      end
      bus(0, `REG_RETRIES, 0);
      cmp("retries", nbusy, q[15:0]);
      bus(0, `REG_FIELDS, 0);
      cmp("fields", {blk[17], blk[16], 4'h0, el, 2'h0, chk, d, ek}, q);
      bus(0, `REG_RESIDUAL, 0);
      cmp("residual", (op == 3 || op == 4) ? 32'h123 : 32'h0, q);
   endtask

   // unknown opcode finishes with error and no command offered
   task automatic t_bad_op();
      for (int i = 0; i < 40; i++)
         host.mem[8'hC0 + i] = 8'h00;
      host.mem[8'hC0] = 8'h05;
      issues = 0;
      bus(1, `REG_BLOCK_ADDR, 32'hC0);
      bus(1, `REG_CTRL, 32'h1);
      repeat (60) @(posedge clk);
      bus(0, `REG_STATUS, 0);
      cmp("bad_status", {8'h05, 8'h00, `RES_BAD_OP, 8'h02}, q);
      cmp("bad_issues", 0, issues);
   endtask

   // main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_block(8'h20, `OP_INIT, 8'h00, 8'h06, 0);
      t_block(8'h80, `OP_INIT, 8'hE8, 8'h0C, 0);
      t_block(8'h20, `OP_SG, 8'h10, 8'h0D, 0);
      t_block(8'h40, `OP_RESID, 8'h18, 8'h01, 0);
      t_block(8'h40, `OP_SG_RESID, 8'h00, 8'h0A, 0);
      t_block(8'h80, `OP_BDR, 8'h00, 8'h0C, 0);
      t_block(8'h20, `OP_INIT, 8'h10, 8'h06, 2);
      t_bad_op();
      finish_test();
   end
endmodule
